// *** pkg/sbp2_regs_defines.svh ***
// Offsets, field positions, reset values and sizes of the SBP-2 register group.
`ifndef SBP2_REGS_DEFINES_SVH
`define SBP2_REGS_DEFINES_SVH

`define ADDR_W            12
`define OFS_AGENT_STATUS  12'h064
`define OFS_PARAM_DATA    12'h06c
`define OFS_BODY_PORT     12'h070
`define OFS_FINAL_PORT    12'h074
`define OFS_DATA_PORT     12'h078
`define OFS_DATA_HI       12'h07a
`define OFS_DATA_LO       12'h07b
`define OFS_RSVD_WORD     12'h07c
`define OFS_PARAM_CTRL    12'h60c
`define OFS_PARAM_CTRL_LB 12'h60f

`define LOGIN_VALID_BIT   7
`define CMD_STATE_LSB     5
`define UNSOL_SEND_BIT    4
`define PARAM_ADDR_LSB    2
`define PARAM_RD_BIT      1
`define PARAM_WR_BIT      0

`define RST_BYTE          8'h00
`define RST_QUAD          32'h0000_0000
`define RST_BLOCK         12'h000
`define RST_COUNT         13'h0000
`define BLOCK_MAX         12'hfff

`define PRAM_DEPTH        48
`define FIFO_DEPTH        8
`define STAT_W            33
`define DATA_W            16

`endif

// *** pkg/sbp2_regs_pkg.sv ***
// Types shared by the SBP-2 register group.
package sbp2_regs_pkg;

  typedef enum logic [1:0] {
    AGENT_RESET     = 2'b00,
    AGENT_ACTIVE    = 2'b01,
    AGENT_SUSPENDED = 2'b10,
    AGENT_DEAD      = 2'b11
  } agent_state_e;

  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_LOAD = 2'b01,
    XFER_SEND = 2'b10
  } xfer_state_e;

endpackage

// *** sim/far_side_model.sv ***
// Model of the initiator that takes status quadlets and data words.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_stall,
  input wire logic        i_stat_valid,
  input wire logic [31:0] i_stat_data,
  input wire logic        i_stat_last,
  input wire logic        i_tx_valid,
  input wire logic [15:0] i_tx_data,
  output logic            o_stat_ready,
  output logic            o_tx_ready
);
  logic [32:0] stat_q[$];
  logic [15:0] tx_q[$];
  // Taking status at all models an initiator that enabled unsolicited status.
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_stat_ready <= 1'b0;
      o_tx_ready <= 1'b0;
    end else begin
      o_stat_ready <= !i_stall;
      o_tx_ready <= !i_stall;
      if (i_stat_valid && o_stat_ready) stat_q.push_back({i_stat_last, i_stat_data});
      if (i_tx_valid && o_tx_ready) tx_q.push_back(i_tx_data);
    end
  end
endmodule
`default_nettype wire

// *** sim/sbp2_regs_sva.sv ***
// Assertion checker bound to the SBP-2 register group top module.
`timescale 1ns/1ps
`default_nettype none
`include "sbp2_regs_defines.svh"
module sbp2_regs_sva (
  input wire logic                        i_clk,
  input wire logic                        i_nrst,
  input wire logic [`ADDR_W-1:0]          i_addr,
  input wire logic                        i_wr,
  input wire logic                        i_rd,
  input wire logic [7:0]                  o_rdata,
  input wire logic                        i_login_valid_set,
  input wire logic                        i_cmd_state_upd,
  input wire sbp2_regs_pkg::agent_state_e i_cmd_state,
  input wire sbp2_regs_pkg::agent_state_e o_cmd_agent_state,
  input wire logic                        i_xfer_sm_reset,
  input wire logic                        o_stat_valid,
  input wire logic                        i_stat_ready,
  input wire logic [31:0]                 o_stat_data,
  input wire logic                        o_stat_last,
  input wire logic                        o_tx_valid,
  input wire logic                        i_tx_ready,
  input wire logic [`DATA_W-1:0]          o_tx_data,
  input wire logic                        o_xfer_busy
);
  import sbp2_regs_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  reset_clear_a: assert property ($rose(i_nrst) |-> o_rdata == 8'h00 && !o_stat_valid
    && !o_tx_valid && !o_xfer_busy) else $error("outputs not clear after reset");
  login_read_a: assert property (i_login_valid_set ##1 !i_wr ##1 (i_rd && i_addr == `OFS_AGENT_STATUS)
    |=> o_rdata[7]) else $error("login flag not set");
  state_mirror_a: assert property (i_cmd_state_upd |=> o_cmd_agent_state == $past(i_cmd_state))
    else $error("agent state not loaded");
  state_read_a: assert property (i_rd && !i_wr && !i_cmd_state_upd
    && i_addr == `OFS_AGENT_STATUS |=> o_rdata[6:5] == o_cmd_agent_state)
    else $error("agent state read differs");
  stat_hold_a: assert property (o_stat_valid && !i_stat_ready |=> o_stat_valid
    && $stable(o_stat_data) && $stable(o_stat_last)) else $error("status offer dropped");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready && !i_xfer_sm_reset
    |=> o_tx_valid && $stable(o_tx_data)) else $error("data offer dropped");
  idle_no_tx_a: assert property (!o_xfer_busy |-> !o_tx_valid) else $error("idle offers data");
  reset_idles_a: assert property (i_xfer_sm_reset |=> !o_xfer_busy && !o_tx_valid)
    else $error("transfer reset ignored");
  rsvd_zero_a: assert property (i_rd && i_addr == `OFS_RSVD_WORD |=> o_rdata == 8'h00)
    else $error("reserved read nonzero");
  data_zero_a: assert property (i_rd && (i_addr == `OFS_DATA_HI || i_addr == `OFS_DATA_LO)
    |=> o_rdata == 8'h00) else $error("data field read nonzero");
  cover property (o_stat_valid && i_stat_ready && o_stat_last);
  cover property (o_tx_valid && i_tx_ready);
  cover property (i_xfer_sm_reset && o_xfer_busy);
endmodule
bind sbp2_status_param_fifo_regs sbp2_regs_sva sbp2_regs_sva_i (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_login_valid_set(i_login_valid_set), .i_cmd_state_upd(i_cmd_state_upd),
  .i_cmd_state(i_cmd_state), .o_cmd_agent_state(o_cmd_agent_state),
  .i_xfer_sm_reset(i_xfer_sm_reset), .o_stat_valid(o_stat_valid), .i_stat_ready(i_stat_ready),
  .o_stat_data(o_stat_data), .o_stat_last(o_stat_last), .o_tx_valid(o_tx_valid),
  .i_tx_ready(i_tx_ready), .o_tx_data(o_tx_data), .o_xfer_busy(o_xfer_busy));
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking testbench for the SBP-2 register group.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sbp2_regs_pkg::*;
  logic i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_login_valid_set = 0, i_cmd_state_upd = 0;
  logic i_cmdset_status_send_en = 0, i_xfer_sm_reset = 0, i_orb_valid = 0, i_orb_pt = 0;
  logic [11:0] i_addr = 0;
  logic [7:0] i_wdata = 0, o_rdata;
  logic [15:0] i_orb_data_size = 0, o_tx_data;
  logic [3:0] i_orb_max_payload = 0;
  logic [2:0] i_orb_page_size = 0, i_orb_spd = 0;
  agent_state_e i_cmd_state = AGENT_RESET, o_cmd_agent_state;
  logic o_stat_valid, i_stat_ready, o_stat_last, o_tx_valid, i_tx_ready, o_data_fifo_ready;
  logic o_xfer_busy, stall = 1;
  logic [31:0] o_stat_data;
  int mismatches = 0, n_tests = 0, cycles = 0;
  sbp2_status_param_fifo_regs sbp2_status_param_fifo_regs_i (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_login_valid_set(i_login_valid_set), .i_cmd_state_upd(i_cmd_state_upd),
    .i_cmd_state(i_cmd_state), .o_cmd_agent_state(o_cmd_agent_state),
    .i_cmdset_status_send_en(i_cmdset_status_send_en), .i_xfer_sm_reset(i_xfer_sm_reset),
    .i_orb_valid(i_orb_valid), .i_orb_data_size(i_orb_data_size),
    .i_orb_page_size(i_orb_page_size), .i_orb_page_table_present(i_orb_pt),
    .i_orb_max_payload(i_orb_max_payload), .i_orb_spd(i_orb_spd), .o_stat_valid(o_stat_valid),
    .i_stat_ready(i_stat_ready), .o_stat_data(o_stat_data), .o_stat_last(o_stat_last),
    .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .o_tx_data(o_tx_data),
    .o_data_fifo_ready(o_data_fifo_ready), .o_xfer_busy(o_xfer_busy));
  far_side_model far_side_model_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_stall(stall),
    .i_stat_valid(o_stat_valid), .i_stat_data(o_stat_data), .i_stat_last(o_stat_last),
    .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .o_stat_ready(i_stat_ready),
    .o_tx_ready(i_tx_ready));
  always #12.5 i_clk = ~i_clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(input string name, input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_clk);
    i_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_clk);
    i_rd = 1'b0;
    chk($sformatf("read %h", a), {25'h0, o_rdata}, {25'h0, exp});
  endtask
  task automatic wrq(input logic [11:0] a, input logic [31:0] q);
    for (int i = 0; i < 4; i++) wr(a + 12'(i), q[31-8*i -: 8]);
  endtask
  task automatic orb(input logic [15:0] size, input logic [3:0] mp);
    @(negedge i_clk);
    i_orb_data_size = size;
    i_orb_max_payload = mp;
    i_orb_valid = 1'b1;
    @(negedge i_clk);
    i_orb_valid = 1'b0;
  endtask
  logic [11:0] zero_list[10] = '{12'h064, 12'h06c, 12'h06d, 12'h06e, 12'h06f, 12'h078,
    12'h079, 12'h070, 12'h074, 12'h60f};
  initial begin
    repeat (6) @(negedge i_clk);
    i_nrst = 1'b1;
    foreach (zero_list[i]) rd(zero_list[i], 8'h00);
    $display("test reset values done");
    @(negedge i_clk) i_login_valid_set = 1'b1;
    @(negedge i_clk) i_login_valid_set = 1'b0;
    rd(12'h064, 8'h80);
    for (int s = 0; s < 4; s++) begin
      @(negedge i_clk);
      i_cmd_state = agent_state_e'(s);
      i_cmd_state_upd = 1'b1;
      @(negedge i_clk) i_cmd_state_upd = 1'b0;
      chk("agent state", 33'(o_cmd_agent_state), 33'(s));
      rd(12'h064, {1'b1, 2'(s), 5'h00});
    end
    wr(12'h064, 8'h00);
    $display("test agent status done");
    wrq(12'h06c, 32'h11223344);
    wr(12'h60f, 8'h15);
    repeat (2) @(negedge i_clk);
    rd(12'h60f, 8'h14);
    wrq(12'h06c, 32'h0);
    wr(12'h60f, 8'h16);
    repeat (2) @(negedge i_clk);
    rd(12'h60f, 8'h14);
    for (int i = 0; i < 4; i++) rd(12'h06c + 12'(i), 8'(32'h11223344 >> (24 - 8*i)));
    $display("test parameter access done");
    wr(12'h070, 8'h77);
    wr(12'h071, 8'h66);
    wrq(12'h070, 32'ha1b2c3d4);
    wrq(12'h074, 32'h01020304);
    rd(12'h070, 8'ha1);
    rd(12'h073, 8'hd4);
    chk("status idle", 33'(o_stat_valid), 33'h0);
    wr(12'h064, 8'h10);
    stall = 1'b0;
    for (int k = 0; k < 50 && far_side_model_i.stat_q.size() < 2; k++) @(negedge i_clk);
    repeat (3) @(negedge i_clk);
    chk("status count", 33'(far_side_model_i.stat_q.size()), 33'h2);
    chk("body quadlet", far_side_model_i.stat_q[0], {1'b0, 32'ha1b2c3d4});
    chk("final quadlet", far_side_model_i.stat_q[1], {1'b1, 32'h01020304});
    rd(12'h064, 8'h00);
    i_cmdset_status_send_en = 1'b1;
    wrq(12'h074, 32'h0a0b0c0d);
    for (int k = 0; k < 50 && far_side_model_i.stat_q.size() < 3; k++) @(negedge i_clk);
    chk("enabled quadlet", far_side_model_i.stat_q[2], {1'b1, 32'h0a0b0c0d});
    i_cmdset_status_send_en = 1'b0;
    $display("test status ports done");
    stall = 1'b1;
    orb(16'h0004, 4'h0);
    rd(12'h078, 8'h00);
    rd(12'h079, 8'h04);
    wr(12'h07b, 8'h55);
    wr(12'h07a, 8'hbe);
    wr(12'h07b, 8'hef);
    wr(12'h07a, 8'h12);
    wr(12'h07b, 8'h34);
    repeat (2) @(negedge i_clk);
    chk("tx offered", {o_tx_valid, o_tx_data}, {1'b1, 16'hbeef});
    stall = 1'b0;
    repeat (10) @(negedge i_clk);
    chk("tx count", 33'(far_side_model_i.tx_q.size()), 33'h2);
    chk("tx word", 33'(far_side_model_i.tx_q[1]), 33'h1234);
    chk("busy after send", 33'(o_xfer_busy), 33'h0);
    stall = 1'b1;
    orb(16'h0040, 4'h3);
    rd(12'h079, 8'h20);
    for (int i = 0; i < 9; i++) begin
      wr(12'h07a, 8'(i));
      wr(12'h07b, 8'(i));
    end
    chk("fifo full", {o_data_fifo_ready, o_tx_valid}, 33'h1);
    stall = 1'b0;
    repeat (20) @(negedge i_clk);
    chk("drained count", 33'(far_side_model_i.tx_q.size()), 33'h3);
    chk("last drained", 33'(far_side_model_i.tx_q[2]), 33'h0000);
    chk("still loading", 33'(o_xfer_busy), 33'h1);
    @(negedge i_clk) i_xfer_sm_reset = 1'b1;
    @(negedge i_clk) i_xfer_sm_reset = 1'b0;
    chk("busy after reset", 33'(o_xfer_busy), 33'h0);
    rd(12'h079, 8'h00);
    rd(12'h07c, 8'h00);
    rd(12'h07a, 8'h00);
    i_orb_page_size = 3'h1;
    i_orb_spd = 3'h1;
    orb(16'h0800, 4'hf);
    rd(12'h078, 8'h02);
    $display("test data port done");
    summarize();
  end
endmodule
`default_nettype wire

// *** src/sbp2_status_param_fifo_regs.sv ***
// Register group for SBP-2 agent status, parameter RAM access and status/data FIFO ports.
//
// Functional notes
// - Power-up clears every register bit except parameter RAM and FIFO storage.
// - Management agent sets login valid flag.
// - Two-bit command agent state, mirrored to CSR.
// - Unsolicited send bit drains status FIFO.
// - Unsolicited send bit clears when FIFO empty.
// - Six-bit quadlet address selects parameter RAM.
// - Read bit loads buffer, then self-clears.
// - Write bit stores buffer, then self-clears.
// - 32-bit read/write parameter data buffer.
// - Body port pushes all but final quadlet.
// - Final port pushes last quadlet, ends message.
// - Base byte first, then three consecutive bytes.
// - Base byte is most significant byte.
// - Upper byte then lower byte pushes word.
// - Read-only 12-bit block size per ORB.
// - Block size from ORB header fields.
// - Full block written moves data to packetizer.
// - After sending, wait for next data write.
// - Word after data port is reserved.
// - Transfer reset idles machine, clears block size.
// - Command-set status sent after final quadlet.
`timescale 1ns/1ps
`default_nettype none
`include "sbp2_regs_defines.svh"
module sbp2_status_param_fifo_regs (
  input  wire logic                        i_clk,
  input  wire logic                        i_nrst,
  input  wire logic [`ADDR_W-1:0]          i_addr,
  input  wire logic [7:0]                  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [7:0]                  o_rdata,
  input  wire logic                        i_login_valid_set,
  input  wire logic                        i_cmd_state_upd,
  input  wire sbp2_regs_pkg::agent_state_e i_cmd_state,
  output sbp2_regs_pkg::agent_state_e      o_cmd_agent_state,
  input  wire logic                        i_cmdset_status_send_en,
  input  wire logic                        i_xfer_sm_reset,
  input  wire logic                        i_orb_valid,
  input  wire logic [15:0]                 i_orb_data_size,
  input  wire logic [2:0]                  i_orb_page_size,
  input  wire logic                        i_orb_page_table_present,
  input  wire logic [3:0]                  i_orb_max_payload,
  input  wire logic [2:0]                  i_orb_spd,
  output logic                             o_stat_valid,
  input  wire logic                        i_stat_ready,
  output logic      [31:0]                 o_stat_data,
  output logic                             o_stat_last,
  output logic                             o_tx_valid,
  input  wire logic                        i_tx_ready,
  output logic      [`DATA_W-1:0]          o_tx_data,
  output logic                             o_data_fifo_ready,
  output logic                             o_xfer_busy
);
  import sbp2_regs_pkg::*;

  // Byte k of a quadlet, byte 0 being the most significant one.
  function automatic logic [7:0] quad_byte(input logic [31:0] q, input logic [1:0] k);
    logic [7:0] b;
    b = 8'h00;
    case (k)
      2'b00:   b = q[31:24];
      2'b01:   b = q[23:16];
      2'b10:   b = q[15:8];
      default: b = q[7:0];
    endcase
    return b;
  endfunction

  // Bytes per transfer limited by payload, speed, page size and data size.
  function automatic logic [11:0] calc_block(input logic [15:0] dsz, input logic [2:0] pgsz,
                                             input logic pt, input logic [3:0] mp,
                                             input logic [2:0] spd);
    logic [17:0] lim;
    logic [17:0] spd_lim;
    logic [17:0] pg_lim;
    lim     = 18'h00001 << ({1'b0, mp} + 5'h02);
    spd_lim = 18'h00200 << spd;
    pg_lim  = 18'h00001 << ({2'b00, pgsz} + 5'h08);
    if (spd_lim < lim) begin
      lim = spd_lim;
    end
    if ((pgsz != 3'h0) && (pg_lim < lim)) begin
      lim = pg_lim;
    end
    if (!pt && ({2'b00, dsz} < lim)) begin
      lim = {2'b00, dsz};
    end
    if (lim > {6'h00, `BLOCK_MAX}) begin
      lim = {6'h00, `BLOCK_MAX};
    end
    return lim[11:0];
  endfunction

  logic        login_valid;
  logic        unsol_send;
  logic [31:0] param_buffer;
  logic [5:0]  param_addr;
  logic        param_rd;
  logic        param_wr;
  logic [31:0] pram [`PRAM_DEPTH];
  logic        stk_busy;
  logic        stk_port;
  logic [1:0]  stk_idx;
  logic [23:0] stk_bytes;
  logic [31:0] body_q;
  logic [31:0] final_q;
  logic        final_loaded;
  logic [7:0]  data_hi;
  logic        data_hi_ok;
  logic [11:0] block_byte_count;
  logic [12:0] loaded;
  xfer_state_e xfer_state;
  logic [7:0]  next_rdata;

  logic        wr_status;
  logic        wr_param_buffer;
  logic        wr_pctrl;
  logic        stk_sel;
  logic [1:0]  stk_k;
  logic        stk_match;
  logic        stat_push;
  logic        stat_in_ready;
  logic        stat_out_valid;
  logic        stat_pop_ok;
  logic        stat_drain;
  logic [32:0] stat_out;
  logic        data_push_req;
  logic        data_in_ready;
  logic        data_push;
  logic        data_full;
  logic        data_out_valid;
  logic        tx_enable;

  assign wr_status = i_wr && (i_addr == `OFS_AGENT_STATUS);
  assign wr_param_buffer  = i_wr && (i_addr[`ADDR_W-1:2] == `OFS_PARAM_DATA >> 2);
  assign wr_pctrl  = i_wr && (i_addr == `OFS_PARAM_CTRL_LB);
  assign stk_sel   = (i_addr[`ADDR_W-1:3] == `OFS_BODY_PORT >> 3);
  assign stk_k     = i_addr[1:0];
  assign stk_match = stk_busy && (stk_port == i_addr[2]) && (stk_idx == stk_k);
  assign stat_push = i_wr && stk_sel && (stk_k == 2'b11) && stk_match;

  // Agent status byte: login flag, agent state and unsolicited send request.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      login_valid       <= 1'b0;
      o_cmd_agent_state <= AGENT_RESET;
    end else begin
      if (wr_status) begin
        login_valid       <= i_wdata[`LOGIN_VALID_BIT];
        o_cmd_agent_state <= agent_state_e'(i_wdata[`CMD_STATE_LSB +: 2]);
      end
      if (i_login_valid_set) begin
        login_valid <= 1'b1;
      end
      if (i_cmd_state_upd) begin
        o_cmd_agent_state <= i_cmd_state;
      end
    end
  end

  // Request is dropped once the status FIFO has run dry; a new request wins.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      unsol_send <= 1'b0;
    end else if (wr_status && i_wdata[`UNSOL_SEND_BIT]) begin
      unsol_send <= 1'b1;
    end else if (wr_status) begin
      unsol_send <= 1'b0;
    end else if (!stat_out_valid && !stat_push) begin
      unsol_send <= 1'b0;
    end
  end

  // Final quadlet seen; used to confirm command-set status.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      final_loaded <= 1'b0;
    end else if (stat_push && stk_port) begin
      final_loaded <= 1'b1;
    end else if (!stat_out_valid) begin
      final_loaded <= 1'b0;
    end
  end

  assign stat_drain   = unsol_send || (i_cmdset_status_send_en && final_loaded);
  assign stat_pop_ok  = i_stat_ready && stat_drain;
  assign o_stat_valid = stat_out_valid && stat_drain;
  assign o_stat_data  = stat_out[31:0];
  assign o_stat_last  = stat_out[32];

  // Parameter control and data buffer.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      param_addr   <= 6'h00;
      param_rd     <= 1'b0;
      param_wr     <= 1'b0;
      param_buffer <= `RST_QUAD;
    end else begin
      if (wr_pctrl) begin
        param_addr <= i_wdata[`PARAM_ADDR_LSB +: 6];
        param_rd   <= i_wdata[`PARAM_RD_BIT];
        param_wr   <= i_wdata[`PARAM_WR_BIT];
      end else begin
        param_rd <= 1'b0;
        param_wr <= 1'b0;
      end
      if (wr_param_buffer) begin
        case (i_addr[1:0])
          2'b00:   param_buffer[31:24] <= i_wdata;
          2'b01:   param_buffer[23:16] <= i_wdata;
          2'b10:   param_buffer[15:8]  <= i_wdata;
          default: param_buffer[7:0]   <= i_wdata;
        endcase
      end else if (param_rd) begin
        param_buffer <= (param_addr < 6'(`PRAM_DEPTH)) ? pram[param_addr] : `RST_QUAD;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (param_wr && (param_addr < 6'(`PRAM_DEPTH))) begin
      pram[param_addr] <= param_buffer;
    end
  end

  // Stacking buffer shared by the two status ports.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stk_busy  <= 1'b0;
      stk_port  <= 1'b0;
      stk_idx   <= 2'b00;
      stk_bytes <= 24'h000000;
    end else if ((i_wr || i_rd) && stk_sel && (stk_k == 2'b00)) begin
      stk_busy  <= i_wr;
      stk_port  <= i_addr[2];
      stk_idx   <= 2'b01;
      stk_bytes <= {i_wdata, 16'h0000};
    end else if (i_wr && stk_sel) begin
      if (stk_match && (stk_k != 2'b11)) begin
        stk_idx <= stk_idx + 2'b01;
        if (stk_k == 2'b01) begin
          stk_bytes[15:8] <= i_wdata;
        end else begin
          stk_bytes[7:0] <= i_wdata;
        end
      end else begin
        stk_busy <= 1'b0;
      end
    end
  end

  // Last quadlet accepted by each port, for read-back.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      body_q  <= `RST_QUAD;
      final_q <= `RST_QUAD;
    end else if (stat_push && stat_in_ready) begin
      if (stk_port) begin
        final_q <= {stk_bytes, i_wdata};
      end else begin
        body_q <= {stk_bytes, i_wdata};
      end
    end
  end

  sync_fifo #(
    .WIDTH (`STAT_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_status_fifo (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_flush     (1'b0),
    .i_in_valid  (stat_push),
    .o_in_ready  (stat_in_ready),
    .i_in_data   ({stk_port, stk_bytes, i_wdata}),
    .o_out_valid (stat_out_valid),
    .i_out_ready (stat_pop_ok),
    .o_out_data  (stat_out),
    .o_full      ()
  );

  // Data FIFO load port: upper byte held until the lower byte arrives.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      data_hi    <= `RST_BYTE;
      data_hi_ok <= 1'b0;
    end else if (i_wr && (i_addr == `OFS_DATA_HI)) begin
      data_hi    <= i_wdata;
      data_hi_ok <= 1'b1;
    end else if (i_wr && (i_addr == `OFS_DATA_LO)) begin
      data_hi_ok <= 1'b0;
    end
  end

  assign data_push_req     = i_wr && (i_addr == `OFS_DATA_LO) && data_hi_ok;
  assign o_data_fifo_ready = data_in_ready && (xfer_state != XFER_SEND);
  assign data_push         = data_push_req && o_data_fifo_ready;
  assign tx_enable         = (xfer_state == XFER_SEND) || ((xfer_state == XFER_LOAD) && data_full);
  assign o_tx_valid        = data_out_valid && tx_enable;
  assign o_xfer_busy       = (xfer_state != XFER_IDLE);

  sync_fifo #(
    .WIDTH (`DATA_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_data_fifo (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_flush     (i_xfer_sm_reset),
    .i_in_valid  (data_push_req && (xfer_state != XFER_SEND)),
    .o_in_ready  (data_in_ready),
    .i_in_data   ({data_hi, i_wdata}),
    .o_out_valid (data_out_valid),
    .i_out_ready (i_tx_ready && tx_enable),
    .o_out_data  (o_tx_data),
    .o_full      (data_full)
  );

  // Block size from the latest command block ORB.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      block_byte_count <= `RST_BLOCK;
    end else if (i_xfer_sm_reset) begin
      block_byte_count <= `RST_BLOCK;
    end else if (i_orb_valid) begin
      block_byte_count <= calc_block(i_orb_data_size, i_orb_page_size,
                                     i_orb_page_table_present, i_orb_max_payload, i_orb_spd);
    end
  end

  // Data transfer control.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      xfer_state <= XFER_IDLE;
      loaded     <= `RST_COUNT;
    end else if (i_xfer_sm_reset) begin
      xfer_state <= XFER_IDLE;
      loaded     <= `RST_COUNT;
    end else begin
      case (xfer_state)
        XFER_IDLE: begin
          if (data_push) begin
            xfer_state <= XFER_LOAD;
            loaded     <= 13'h0002;
          end
        end
        XFER_LOAD: begin
          if ((block_byte_count != `RST_BLOCK) && (loaded >= {1'b0, block_byte_count})) begin
            xfer_state <= XFER_SEND;
          end else if (data_push) begin
            loaded <= loaded + 13'h0002;
          end
        end
        XFER_SEND: begin
          if (!data_out_valid) begin
            xfer_state <= XFER_IDLE;
            loaded     <= `RST_COUNT;
          end
        end
        default: begin
          xfer_state <= XFER_IDLE;
          loaded     <= `RST_COUNT;
        end
      endcase
    end
  end

  // Read data mux.
  always_comb begin
    next_rdata = 8'h00;
    if (i_addr == `OFS_AGENT_STATUS) begin
      next_rdata = {login_valid, o_cmd_agent_state, unsol_send, 4'h0};
    end else if (i_addr[`ADDR_W-1:2] == `OFS_PARAM_DATA >> 2) begin
      next_rdata = quad_byte(param_buffer, i_addr[1:0]);
    end else if (i_addr[`ADDR_W-1:2] == `OFS_BODY_PORT >> 2) begin
      next_rdata = quad_byte(body_q, i_addr[1:0]);
    end else if (i_addr[`ADDR_W-1:2] == `OFS_FINAL_PORT >> 2) begin
      next_rdata = quad_byte(final_q, i_addr[1:0]);
    end else if (i_addr == `OFS_DATA_PORT) begin
      next_rdata = {4'h0, block_byte_count[11:8]};
    end else if (i_addr == `OFS_DATA_PORT + 12'h001) begin
      next_rdata = block_byte_count[7:0];
    end else if (i_addr == `OFS_PARAM_CTRL_LB) begin
      next_rdata = {param_addr, param_rd, param_wr};
    end
  end
  // Data field and the reserved word fall through to zero.

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= `RST_BYTE;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// *** src/sync_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a flush.
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data,
  output logic                  o_full
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  assign o_full      = (count == CW'(DEPTH));
  assign o_in_ready  = !o_full;
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
